/* File: common/lpmc_params.svh */
// constants for the low power mode controller
// How it works
// - any reset leaves device in Run
// - regulator on after reset, Run and Stop
// - regulator off in Standby, contents lost
// - held in reset while supply low
// - Sleep gates CPU, Stop all, Standby power
// - peripheral clocks gateable by software in Run
// - handler bit clear: wait enters Sleep now
// - handler bit set: Sleep on handler return
// - Sleep needs deep select zero
// - pins hold state in Sleep and Stop
// - interrupt wakes Sleep entered by interrupt wait
// - event wakes event wait; pending counts optionally
// - event-mode line wakes without pending bit
// - Stop halts clocks and fast oscillators
// - Stop needs deep set, power-down clear
// - flash programming postpones Stop entry
// - bus transfer postpones Stop entry
// - pending flags abandon Stop entry
// - started watchdog runs until reset
// - rtc and slow crystal follow enable bits
// - Stop exit selects internal fast oscillator
// - Stop wake by line mode matching wait kind
// - power-down select leads to Standby
`ifndef LPMC_PARAMS_SVH
`define LPMC_PARAMS_SVH
`define LPMC_ADDR_W       4
`define LPMC_CTRL_OFS     4'h0
`define LPMC_PCLK_OFS     4'h4
`define LPMC_STAT_OFS     4'h8
`define LPMC_CTRL_HANDLER 0
`define LPMC_CTRL_DEEP    1
`define LPMC_CTRL_EVPEND  2
`define LPMC_CTRL_PDOWN   3
`define LPMC_CTRL_WDOG    4
`define LPMC_CTRL_WUF     5
`define LPMC_PCLK_RST     32'hFFFFFFFF
`define LPMC_SRC_FAST_INT 2'h0
`endif

/* File: common/lpmc_pkg.sv */
// types of the low power mode controller
`default_nettype none
package lpmc_pkg;
  typedef enum logic [2:0] {
    LPMC_RUN, LPMC_SLEEP, LPMC_STOP_WAIT, LPMC_STOP, LPMC_WAKE, LPMC_STANDBY
  } lpmc_state_e;
  typedef struct packed {
    logic wait_for_interrupt_instr;
    logic wait_for_event_instr;
    logic isr_return;
  } lpmc_cpu_s;
  typedef struct packed {
    logic cpu_clk_en;
    logic core_clk_en;
    logic fast_osc_en;
    logic regulator_on;
    logic pin_hold;
  } lpmc_power_s;
endpackage
`default_nettype wire

/* File: rtl/lpmc_ctrl.sv */
// power mode sequencer with its control registers
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`include "lpmc_params.svh"
`default_nettype none
module lpmc_ctrl
  import lpmc_pkg::*;
#(
  parameter int NPERIPH = 32
) (
  // clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  // register port
  input  wire logic [`LPMC_ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [31:0]             reg_rdata,
  // cpu side
  input  wire lpmc_cpu_s               cpu,
  input  wire logic                    irq_acked,
  input  wire logic                    irq_line_wake,
  input  wire logic                    event_line_wake,
  input  wire logic                    periph_irq_pending,
  input  wire logic                    event_pending_any,
  input  wire logic                    rtc_alarm_flag,
  // stop entry holds
  input  wire logic                    flash_busy,
  input  wire logic                    apb_busy,
  // supply and oscillator status
  input  wire logic                    supply_ok,
  input  wire logic                    fast_osc_ready,
  input  wire logic                    wdog_hw_option,
  input  wire logic                    rtc_run_enable_bit,
  input  wire logic                    slow_crystal_on_bit,
  // power and clock controls
  output lpmc_power_s                  power,
  output logic [NPERIPH-1:0]           periph_clk_en,
  output logic [1:0]                   sysclk_src,
  output logic                         wdog_run,
  output logic                         rtc_run,
  output logic                         slow_osc_run,
  output logic                         sys_reset_hold
);

  lpmc_state_e         state_r;
  lpmc_state_e         state_nxt;
  logic [5:0]          ctrl_r;
  logic [NPERIPH-1:0]  pclk_r;
  logic                via_wfe_r;
  logic                wake_ev;
  logic                stop_block;
  logic                wait_req;
  logic                wait_is_wfe;

  function automatic logic pend_any(input logic p, input logic e,
                                    input logic a);
    pend_any = p | e | a;
  endfunction

  assign wait_is_wfe = cpu.wait_for_event_instr;
  // instruction wait, or return from last handler when armed
  assign wait_req = cpu.wait_for_interrupt_instr | cpu.wait_for_event_instr
                  | (cpu.isr_return & ctrl_r[`LPMC_CTRL_HANDLER]);
  assign stop_block = pend_any(periph_irq_pending, event_pending_any,
                               rtc_alarm_flag);

  // wake conditions per entry kind
  always_comb begin
    wake_ev = 1'b0;
    if (state_r == LPMC_SLEEP) begin
      if (via_wfe_r)
        wake_ev = event_line_wake
                | (ctrl_r[`LPMC_CTRL_EVPEND] & periph_irq_pending);
      else
        wake_ev = irq_acked;
    end else if (state_r == LPMC_STOP) begin
      wake_ev = via_wfe_r ? event_line_wake : irq_line_wake;
    end
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      LPMC_RUN: begin
        if (wait_req && !ctrl_r[`LPMC_CTRL_DEEP]) begin
          // sleep-now on wait instr; sleep-on-exit on handler return only
          if (!ctrl_r[`LPMC_CTRL_HANDLER] && (cpu.wait_for_interrupt_instr || cpu.wait_for_event_instr))
            state_nxt = LPMC_SLEEP;
          else if (ctrl_r[`LPMC_CTRL_HANDLER] && cpu.isr_return)
            state_nxt = LPMC_SLEEP;
        end else if ((cpu.wait_for_interrupt_instr || cpu.wait_for_event_instr) && ctrl_r[`LPMC_CTRL_DEEP]) begin
          if (!stop_block) begin
            if (ctrl_r[`LPMC_CTRL_PDOWN])
              state_nxt = LPMC_STANDBY;
            else
              state_nxt = LPMC_STOP_WAIT;
          end
        end
      end
      LPMC_SLEEP:
        if (wake_ev)
          state_nxt = LPMC_RUN;
      LPMC_STOP_WAIT:
        if (stop_block)
          state_nxt = LPMC_RUN;
        else if (!flash_busy && !apb_busy)
          state_nxt = LPMC_STOP;
      LPMC_STOP:
        if (wake_ev)
          state_nxt = LPMC_WAKE;
      LPMC_WAKE:
        if (fast_osc_ready)
          state_nxt = LPMC_RUN;
      LPMC_STANDBY:
        state_nxt = LPMC_STANDBY;
      default:
        state_nxt = LPMC_RUN;
    endcase
    // low supply forces Run, so power outputs follow too
    if (!supply_ok)
      state_nxt = LPMC_RUN;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      state_r <= LPMC_RUN;
    else if (!supply_ok)
      state_r <= LPMC_RUN;
    else
      state_r <= state_nxt;
  end

  // remember which wait kind started the low power phase
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      via_wfe_r <= 1'b0;
    else if (state_r == LPMC_RUN && state_nxt != LPMC_RUN)
      via_wfe_r <= wait_is_wfe & ~cpu.isr_return;
  end

  // control register; watchdog start is sticky until reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      ctrl_r <= 6'h00;
    else begin
      if (reg_wr && reg_addr == `LPMC_CTRL_OFS) begin
        ctrl_r[3:0] <= reg_wdata[3:0];
        ctrl_r[`LPMC_CTRL_WUF] <= ctrl_r[`LPMC_CTRL_WUF]
                                & ~reg_wdata[`LPMC_CTRL_WUF];
      end
      if (reg_wr && reg_addr == `LPMC_CTRL_OFS
          && reg_wdata[`LPMC_CTRL_WDOG])
        ctrl_r[`LPMC_CTRL_WDOG] <= 1'b1;
      if (wdog_hw_option)
        ctrl_r[`LPMC_CTRL_WDOG] <= 1'b1;
      // wake flag set wins over clear; cleared on standby entry
      if (state_r == LPMC_WAKE && state_nxt == LPMC_RUN)
        ctrl_r[`LPMC_CTRL_WUF] <= 1'b1;
      else if (state_nxt == LPMC_STANDBY && state_r == LPMC_RUN)
        ctrl_r[`LPMC_CTRL_WUF] <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      pclk_r <= NPERIPH'(`LPMC_PCLK_RST);
    else if (reg_wr && reg_addr == `LPMC_PCLK_OFS)
      pclk_r <= reg_wdata[NPERIPH-1:0];
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      reg_rdata <= 32'h00000000;
    else if (reg_rd) begin
      unique case (reg_addr)
        `LPMC_CTRL_OFS: reg_rdata <= {26'h0000000, ctrl_r};
        `LPMC_PCLK_OFS: reg_rdata <= 32'(pclk_r);
        `LPMC_STAT_OFS: reg_rdata <= {29'h00000000, state_r};
        default:        reg_rdata <= 32'h00000000;
      endcase
    end
  end

  // power, clock and pin controls from the next state
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      power          <= '{cpu_clk_en: 1'b1, core_clk_en: 1'b1,
                          fast_osc_en: 1'b1, regulator_on: 1'b1,
                          pin_hold: 1'b0};
      periph_clk_en  <= NPERIPH'(`LPMC_PCLK_RST);
      sysclk_src     <= `LPMC_SRC_FAST_INT;
      sys_reset_hold <= 1'b1;
    end else begin
      sys_reset_hold       <= ~supply_ok;
      power.cpu_clk_en     <= state_nxt == LPMC_RUN;
      power.core_clk_en    <= state_nxt == LPMC_RUN
                            || state_nxt == LPMC_SLEEP
                            || state_nxt == LPMC_STOP_WAIT;
      power.fast_osc_en    <= state_nxt != LPMC_STOP
                            && state_nxt != LPMC_STANDBY;
      power.regulator_on   <= state_nxt != LPMC_STANDBY;
      power.pin_hold       <= state_nxt != LPMC_RUN
                            && state_nxt != LPMC_STANDBY;
      periph_clk_en        <= pclk_r;
      if (state_r == LPMC_STOP && state_nxt == LPMC_WAKE)
        sysclk_src <= `LPMC_SRC_FAST_INT;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wdog_run     <= 1'b0;
      rtc_run      <= 1'b0;
      slow_osc_run <= 1'b0;
    end else begin
      wdog_run     <= ctrl_r[`LPMC_CTRL_WDOG] | wdog_hw_option;
      rtc_run      <= rtc_run_enable_bit;
      slow_osc_run <= slow_crystal_on_bit;
    end
  end

endmodule
`default_nettype wire

/* File: verification/lpmc_ctrl_assertions.sv */
// port assertions of the power mode sequencer
`include "lpmc_params.svh"
`default_nettype none
module lpmc_ctrl_assertions
  import lpmc_pkg::*;
(
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // holds and flags
  input wire logic        flash_busy,
  input wire logic        apb_busy,
  input wire logic        periph_irq_pending,
  input wire logic        event_pending_any,
  input wire logic        rtc_alarm_flag,
  input wire logic        supply_ok,
  input wire logic        fast_osc_ready,
  // controls
  input wire lpmc_power_s power,
  input wire logic [1:0]  sysclk_src,
  input wire logic        wdog_run,
  input wire logic        sys_reset_hold
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_hold; !supply_ok |=> sys_reset_hold; endproperty
  a_hold: assert property (p_hold) else $error("no reset hold");
  property p_pins; !power.cpu_clk_en && power.regulator_on |-> power.pin_hold;
  endproperty
  a_pins: assert property (p_pins) else $error("pins free");
  property p_clk; power.regulator_on && !power.fast_osc_en |->
    !power.core_clk_en; endproperty
  a_clk: assert property (p_clk) else $error("core clock on");
  property p_busy; (flash_busy || apb_busy) && power.fast_osc_en |=>
    power.fast_osc_en; endproperty
  a_busy: assert property (p_busy) else $error("stop while busy");
  property p_pend; (periph_irq_pending || event_pending_any || rtc_alarm_flag)
    && power.cpu_clk_en |=> power.fast_osc_en; endproperty
  a_pend: assert property (p_pend) else $error("stop with pending");
  property p_src; $rose(power.core_clk_en) |->
    sysclk_src == `LPMC_SRC_FAST_INT; endproperty
  a_src: assert property (p_src) else $error("wrong clock source");
  property p_osc; !power.core_clk_en && !fast_osc_ready && supply_ok |=>
    !power.core_clk_en; endproperty
  a_osc: assert property (p_osc) else $error("clock before stable");
  property p_wdog; wdog_run |=> wdog_run; endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog stopped");
endmodule
bind lpmc_ctrl lpmc_ctrl_assertions i_lpmc_ctrl_assertions (
  .core_clk(core_clk), .rst(rst), .flash_busy(flash_busy),
  .apb_busy(apb_busy), .periph_irq_pending(periph_irq_pending),
  .event_pending_any(event_pending_any), .rtc_alarm_flag(rtc_alarm_flag),
  .supply_ok(supply_ok), .fast_osc_ready(fast_osc_ready), .power(power),
  .sysclk_src(sysclk_src), .wdog_run(wdog_run),
  .sys_reset_hold(sys_reset_hold)
);
`default_nettype wire

/* File: verification/lpmc_far.sv */
// far side model: fast oscillator startup
`default_nettype none
module lpmc_far
  import lpmc_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // controller side
  input  wire lpmc_power_s power,
  output var  logic        fast_osc_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] start_cnt_r;
  // stable only some cycles after enable
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst || !power.fast_osc_en) begin
      start_cnt_r <= 3'h0;
    end else if (start_cnt_r != 3'h7) begin
      start_cnt_r <= start_cnt_r + 3'h1;
    end
  end
  assign fast_osc_ready = (start_cnt_r == 3'h7);
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// self-checking bench of the power mode sequencer
`include "lpmc_params.svh"
`default_nettype none
module tb_top
  import lpmc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, osc_rdy, wdog_run, hold;
  logic        rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, supply_ok = 1'b1;
  logic        irq = 1'b0, ev = 1'b0, rtc_en = 1'b0, slow_en = 1'b0;
  logic        rtc_run, slow_run;
  logic [1:0]  busy = 2'h0, sysclk_src;
  logic [2:0]  pend = 3'h0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, pclk;
  lpmc_cpu_s   cpu = '0;
  lpmc_power_s power;
  int          errors = 0, tests_run = 0, cycles = 0;
  lpmc_ctrl i_lpmc_ctrl (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cpu(cpu), .irq_acked(irq),
    .irq_line_wake(irq), .event_line_wake(ev), .periph_irq_pending(pend[0]),
    .event_pending_any(pend[1]), .rtc_alarm_flag(pend[2]),
    .flash_busy(busy[0]), .apb_busy(busy[1]), .supply_ok(supply_ok),
    .fast_osc_ready(osc_rdy), .wdog_hw_option(1'b0),
    .rtc_run_enable_bit(rtc_en), .slow_crystal_on_bit(slow_en),
    .power(power), .periph_clk_en(pclk), .sysclk_src(sysclk_src),
    .wdog_run(wdog_run), .rtc_run(rtc_run), .slow_osc_run(slow_run),
    .sys_reset_hold(hold)
  );
  lpmc_far i_lpmc_far (
    .core_clk(core_clk), .rst(rst), .power(power), .fast_osc_ready(osc_rdy)
  );
  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    cmp(reg_rdata, e);
  endtask
  task automatic go(input lpmc_cpu_s c);
    @(posedge core_clk);
    cpu <= c;
    @(posedge core_clk);
    cpu <= '0;
  endtask
  task automatic wk(input logic i, input logic e);
    @(posedge core_clk);
    irq <= i;
    ev <= e;
    @(posedge core_clk);
    irq <= 1'b0;
    ev <= 1'b0;
  endtask
  task automatic t_reset();
    cmp(power, 5'h1E);
    cmp(pclk, `LPMC_PCLK_RST);
    cmp(hold, 1'b0);
    rd(`LPMC_STAT_OFS, 0);
    $display("reset test done");
  endtask
  task automatic t_sleep(input lpmc_cpu_s c);
    go(c);
    rd(`LPMC_STAT_OFS, 1);
    cmp({power.cpu_clk_en, power.core_clk_en, power.pin_hold}, 3'h3);
    wk(c.wait_for_interrupt_instr, c.wait_for_event_instr);
    rd(`LPMC_STAT_OFS, 0);
    $display("sleep test done");
  endtask
  task automatic t_handler();
    wr(`LPMC_CTRL_OFS, 32'h1);
    go(3'h4);
    rd(`LPMC_STAT_OFS, 0);
    go(3'h1);
    rd(`LPMC_STAT_OFS, 1);
    wk(1'b1, 1'b0);
    wr(`LPMC_CTRL_OFS, 32'h2);
    $display("handler test done");
  endtask
  task automatic t_stop(input lpmc_cpu_s c, input int b);
    @(posedge core_clk);
    busy <= 2'(1 << b);
    go(c);
    repeat (3) @(posedge core_clk);
    rd(`LPMC_STAT_OFS, 2);
    @(posedge core_clk);
    busy <= 2'h0;
    repeat (3) @(posedge core_clk);
    rd(`LPMC_STAT_OFS, 3);
    cmp(power.fast_osc_en, 1'b0);
    wk(c.wait_for_interrupt_instr, c.wait_for_event_instr);
    repeat (12) @(posedge core_clk);
    rd(`LPMC_STAT_OFS, 0);
    cmp(sysclk_src, `LPMC_SRC_FAST_INT);
    rd(`LPMC_CTRL_OFS, 32'h22);
    wr(`LPMC_CTRL_OFS, 32'h22);
    $display("stop test done");
  endtask
  task automatic t_abort();
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk);
      pend <= 3'(1 << i);
      go(3'h4);
      rd(`LPMC_STAT_OFS, 0);
      @(posedge core_clk);
      pend <= 3'h0;
    end
    $display("abort test done");
  endtask
  task automatic t_misc();
    wr(`LPMC_PCLK_OFS, 32'h0000A5A5);
    rd(4'hC, 0);
    cmp(pclk, 32'h0000A5A5);
    wr(`LPMC_CTRL_OFS, 32'h10);
    wr(`LPMC_CTRL_OFS, 32'hA);
    cmp(wdog_run, 1'b1);
    @(posedge core_clk);
    rtc_en <= 1'b1;
    repeat (2) @(posedge core_clk);
    cmp({rtc_run, slow_run}, 2'h2);
    slow_en <= 1'b1;
    rtc_en <= 1'b0;
    repeat (2) @(posedge core_clk);
    cmp({rtc_run, slow_run}, 2'h1);
    slow_en <= 1'b0;
    $display("gating test done");
  endtask
  task automatic t_standby();
    go(3'h4);
    repeat (2) @(posedge core_clk);
    rd(`LPMC_STAT_OFS, 5);
    cmp(power.regulator_on, 1'b0);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd(`LPMC_STAT_OFS, 0);
    cmp(wdog_run, 1'b0);
    @(posedge core_clk);
    supply_ok <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    cmp(hold, 1'b1);
    rd(`LPMC_STAT_OFS, 0);
    @(posedge core_clk);
    supply_ok <= 1'b1;
    $display("standby test done");
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    t_reset();
    t_sleep(3'h4);
    t_sleep(3'h2);
    t_handler();
    t_stop(3'h2, 0);
    t_stop(3'h4, 1);
    t_abort();
    t_misc();
    t_standby();
    wrap_up();
  end
endmodule
`default_nettype wire
